// ==== uiq_regs.svh ====
`ifndef UIQ_REGS_SVH
`define UIQ_REGS_SVH
// Contract
// - The divisor high byte survives a software reset and returns to default only on power-on reset.
// - The divisor bytes are reachable only with line format bit 7 set and the line format value not 0xBF.
// - The identification register reports the top pending source: line error 000110, timeout 001100, receive data 000100, transmit holding 000010, modem 000000.
// - An input pin change of state is reported at priority 5 as 110000.
// - A stop character or special character is reported at priority 6 as 010000.
// - A handshake going inactive is reported at the lowest priority, 7, as 100000.
// - Receive trigger bits 7:6 select 8, 16, 56 or 60 characters.
// - Writing one to control bit 2 empties the transmit queue and resets its level tracking.
// - A transmit flush leaves the transmit shift register alone.
// - The flush bit clears itself once the flush is done.
// - Writing zero to the flush bit does nothing to the transmit queue.
// - The transmit trigger field changes only while the enhanced enable bit is set.
// - With queues disabled each side holds one character, other control bits are locked, trigger is one.

// Register byte offsets
`define UIQ_DIV_HIGH_OFF 12'h004
`define UIQ_SRC_ID_OFF 12'h008
`define UIQ_QCTRL_OFF 12'h00C
`define UIQ_LINE_FMT_OFF 12'h010
`define UIQ_EXT_FEAT_OFF 12'h014
`define UIQ_IRQ_STAT_OFF 12'h018
`define UIQ_IRQ_CLR_OFF 12'h01C
`define UIQ_IRQ_EN_OFF 12'h020
`define UIQ_SW_RESET_OFF 12'h024
`define UIQ_THRESH_OFF 12'h028

// Field positions
`define UIQ_LF_DIV_BIT 7
`define UIQ_EF_ENH_BIT 4
`define UIQ_QC_EN_BIT 0
`define UIQ_QC_TXFL_BIT 2

// Reset values and keys
`define UIQ_DIV_HIGH_RST 8'h00
`define UIQ_SRC_ID_RST 8'h01
`define UIQ_LINE_FMT_RST 8'h1D
`define UIQ_BANK_KEY 8'hBF

// Identification codes, bits 5:0
`define UIQ_ID_LINE_ERR 6'h06
`define UIQ_ID_RX_TMO 6'h0C
`define UIQ_ID_RX_DATA 6'h04
`define UIQ_ID_TX_HOLD 6'h02
`define UIQ_ID_MODEM 6'h00
`define UIQ_ID_PIN_CHG 6'h30
`define UIQ_ID_XOFF 6'h10
`define UIQ_ID_HS_DROP 6'h20
`define UIQ_ID_NONE 6'h01

// Trigger levels
`define UIQ_RX_TRIG0 7'h08
`define UIQ_RX_TRIG1 7'h10
`define UIQ_RX_TRIG2 7'h38
`define UIQ_RX_TRIG3 7'h3C
`define UIQ_TX_TRIG0 7'h08
`define UIQ_TX_TRIG1 7'h10
`define UIQ_TX_TRIG2 7'h20
`define UIQ_TX_TRIG3 7'h38
`define UIQ_TRIG_ONE 7'h01

// Flush countdown start; tx_flush_q stays high this many cycles plus two
`define UIQ_FLUSH_CYC 2'h2
`endif

// ==== uiq_pkg.sv ====
package uiq_pkg;
	typedef enum logic [1:0] {
		UIQ_FL_IDLE,
		UIQ_FL_BUSY,
		UIQ_FL_DONE
	} uiq_flush_e;
endpackage

// ==== uiq_prio_enc.sv ====
`timescale 1ns/100ps
`include "uiq_regs.svh"
module uiq_prio_enc (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] pend,
	output logic [5:0] id_q
);
	logic [5:0] id_d;

	always_comb begin
		if (pend[0])
			id_d = `UIQ_ID_LINE_ERR;
		else if (pend[1])
			id_d = `UIQ_ID_RX_TMO;
		else if (pend[2])
			id_d = `UIQ_ID_RX_DATA;
		else if (pend[3])
			id_d = `UIQ_ID_TX_HOLD;
		else if (pend[4])
			id_d = `UIQ_ID_MODEM;
		else if (pend[5])
			id_d = `UIQ_ID_PIN_CHG;
		else if (pend[6])
			id_d = `UIQ_ID_XOFF;
		else if (pend[7])
			id_d = `UIQ_ID_HS_DROP;
		else
			id_d = `UIQ_ID_NONE;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			id_q <= `UIQ_ID_NONE;
		else
			id_q <= id_d;
	end
endmodule // uiq_prio_enc

// ==== uiq_trig_map.sv ====
`timescale 1ns/100ps
`include "uiq_regs.svh"
module uiq_trig_map (
	input wire logic [1:0] rx_sel,
	input wire logic [1:0] tx_sel,
	input wire logic fifo_en,
	output logic [6:0] rx_level,
	output logic [6:0] tx_level
);
	always_comb begin
		case (rx_sel)
			2'h0: rx_level = `UIQ_RX_TRIG0;
			2'h1: rx_level = `UIQ_RX_TRIG1;
			2'h2: rx_level = `UIQ_RX_TRIG2;
			default: rx_level = `UIQ_RX_TRIG3;
		endcase
		case (tx_sel)
			2'h0: tx_level = `UIQ_TX_TRIG0;
			2'h1: tx_level = `UIQ_TX_TRIG1;
			2'h2: tx_level = `UIQ_TX_TRIG2;
			default: tx_level = `UIQ_TX_TRIG3;
		endcase
		if (!fifo_en) begin
			rx_level = `UIQ_TRIG_ONE;
			tx_level = `UIQ_TRIG_ONE;
		end
	end
endmodule // uiq_trig_map

// ==== uiq_ctrl.sv ====
`timescale 1ns/100ps
`include "uiq_regs.svh"
module uiq_ctrl
	import uiq_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] src_pend,
	input wire logic tx_flush_ack,
	output logic tx_flush_q,
	output logic fifo_en_q,
	output logic [7:0] divisor_high_q,
	output logic [6:0] rx_level_q,
	output logic [6:0] tx_level_q,
	output logic irq_q
);
	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	logic wr_en, rd_en, div_ok;
	logic [7:0] line_fmt_q, line_fmt_d, ext_feat_q, ext_feat_d;
	logic [7:0] div_d;
	logic [1:0] rx_trig_q, rx_trig_d, tx_trig_q, tx_trig_d;
	logic fifo_en_d;
	logic [7:0] stat_q, stat_d, en_q, en_d;
	logic [7:0] pend_prev_q;
	logic [5:0] id_q;
	logic [6:0] rx_level, tx_level;
	logic sw_rst;
	uiq_flush_e fl_q, fl_d;
	logic [1:0] fl_cnt_q, fl_cnt_d;
	logic flush_d, irq_d, ack_s1_q, ack_s2_q;
	logic pready_d, pslverr_d;
	logic [31:0] rdata_d;
	logic err_d;

	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && !penable && !pwrite;
	assign div_ok = line_fmt_q[`UIQ_LF_DIV_BIT] &&
		(line_fmt_q != `UIQ_BANK_KEY);
	assign sw_rst = wr_en && (paddr == `UIQ_SW_RESET_OFF) && pwdata[0];

	// --------------------------------------------------------------
	// Configuration registers
	// --------------------------------------------------------------
	always_comb begin
		line_fmt_d = line_fmt_q;
		ext_feat_d = ext_feat_q;
		div_d = divisor_high_q;
		fifo_en_d = fifo_en_q;
		rx_trig_d = rx_trig_q;
		tx_trig_d = tx_trig_q;
		en_d = en_q;
		if (wr_en) begin
			case (paddr)
				`UIQ_LINE_FMT_OFF: line_fmt_d = pwdata[7:0];
				`UIQ_EXT_FEAT_OFF: ext_feat_d = pwdata[7:0];
				`UIQ_IRQ_EN_OFF: en_d = pwdata[7:0];
				`UIQ_DIV_HIGH_OFF: begin
					if (div_ok)
						div_d = pwdata[7:0];
				end
				`UIQ_QCTRL_OFF: begin
					fifo_en_d = pwdata[`UIQ_QC_EN_BIT];
					if (pwdata[`UIQ_QC_EN_BIT]) begin
						rx_trig_d = pwdata[7:6];
						if (ext_feat_q[`UIQ_EF_ENH_BIT])
							tx_trig_d = pwdata[5:4];
					end
				end
				default: ;
			endcase
		end
		if (sw_rst) begin
			// Divisor deliberately kept across a software reset
			line_fmt_d = `UIQ_LINE_FMT_RST;
			ext_feat_d = 8'h00;
			fifo_en_d = 1'b0;
			rx_trig_d = 2'h0;
			tx_trig_d = 2'h0;
			en_d = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			line_fmt_q <= `UIQ_LINE_FMT_RST;
			ext_feat_q <= 8'h00;
			divisor_high_q <= `UIQ_DIV_HIGH_RST;
			fifo_en_q <= 1'b0;
			rx_trig_q <= 2'h0;
			tx_trig_q <= 2'h0;
			en_q <= 8'h00;
		end else begin
			line_fmt_q <= line_fmt_d;
			ext_feat_q <= ext_feat_d;
			divisor_high_q <= div_d;
			fifo_en_q <= fifo_en_d;
			rx_trig_q <= rx_trig_d;
			tx_trig_q <= tx_trig_d;
			en_q <= en_d;
		end
	end

	// --------------------------------------------------------------
	// Transmit flush sequencing
	// --------------------------------------------------------------
	// Flush pulses the queue only; shift register has no reset path here
	always_comb begin
		fl_d = fl_q;
		fl_cnt_d = fl_cnt_q;
		flush_d = 1'b0;
		case (fl_q)
			UIQ_FL_IDLE: begin
				if (wr_en && (paddr == `UIQ_QCTRL_OFF) && fifo_en_q &&
					pwdata[`UIQ_QC_TXFL_BIT]) begin
					fl_d = UIQ_FL_BUSY;
					fl_cnt_d = `UIQ_FLUSH_CYC;
					flush_d = 1'b1;
				end
			end
			UIQ_FL_BUSY: begin
				flush_d = 1'b1;
				if (fl_cnt_q != 2'h0)
					fl_cnt_d = fl_cnt_q - 2'h1;
				if (fl_cnt_q == 2'h0 || ack_s2_q)
					fl_d = UIQ_FL_DONE;
			end
			UIQ_FL_DONE: begin
				fl_d = UIQ_FL_IDLE;
			end
			default: fl_d = UIQ_FL_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fl_q <= UIQ_FL_IDLE;
			fl_cnt_q <= 2'h0;
			tx_flush_q <= 1'b0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			fl_q <= fl_d;
			fl_cnt_q <= fl_cnt_d;
			tx_flush_q <= flush_d;
			ack_s1_q <= tx_flush_ack;
			ack_s2_q <= ack_s1_q;
		end
	end

	// --------------------------------------------------------------
	// Interrupt identification and status
	// --------------------------------------------------------------
	uiq_prio_enc u_prio (
		.clk(clk),
		.reset_n(reset_n),
		.pend(src_pend),
		.id_q(id_q)
	);

	uiq_trig_map u_trig (
		.rx_sel(rx_trig_q),
		.tx_sel(tx_trig_q),
		.fifo_en(fifo_en_q),
		.rx_level(rx_level),
		.tx_level(tx_level)
	);

	always_comb begin
		stat_d = stat_q;
		if (wr_en && (paddr == `UIQ_IRQ_CLR_OFF))
			stat_d = stat_q & ~pwdata[7:0];
		// New source edges win over a same-cycle clear
		stat_d = stat_d | (src_pend & ~pend_prev_q);
		irq_d = |(stat_d & en_d);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stat_q <= 8'h00;
			pend_prev_q <= 8'h00;
			irq_q <= 1'b0;
			rx_level_q <= `UIQ_TRIG_ONE;
			tx_level_q <= `UIQ_TRIG_ONE;
		end else begin
			stat_q <= stat_d;
			pend_prev_q <= src_pend;
			irq_q <= irq_d;
			rx_level_q <= rx_level;
			tx_level_q <= tx_level;
		end
	end

	// --------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------
	always_comb begin
		rdata_d = prdata;
		err_d = 1'b0;
		if (rd_en) begin
			rdata_d = 32'h0000_0000;
			case (paddr)
				`UIQ_DIV_HIGH_OFF: begin
					if (div_ok)
						rdata_d[7:0] = divisor_high_q;
					else
						err_d = 1'b1;
				end
				`UIQ_SRC_ID_OFF: begin
					if (line_fmt_q[`UIQ_LF_DIV_BIT])
						err_d = 1'b1;
					else
						rdata_d[7:0] = {fifo_en_q, fifo_en_q,
							id_q};
				end
				`UIQ_QCTRL_OFF: rdata_d[7:0] = {rx_trig_q, tx_trig_q,
					1'b0, tx_flush_q, 1'b0, fifo_en_q};
				`UIQ_LINE_FMT_OFF: rdata_d[7:0] = line_fmt_q;
				`UIQ_EXT_FEAT_OFF: rdata_d[7:0] = ext_feat_q;
				`UIQ_IRQ_STAT_OFF: rdata_d[7:0] = stat_q;
				`UIQ_IRQ_CLR_OFF: ;
				`UIQ_IRQ_EN_OFF: rdata_d[7:0] = en_q;
				`UIQ_SW_RESET_OFF: ;
				`UIQ_THRESH_OFF: rdata_d[14:0] = {tx_level_q, 1'b0,
					rx_level_q};
				default: err_d = 1'b1;
			endcase
		end else if (psel && !penable && pwrite) begin
			case (paddr)
				`UIQ_DIV_HIGH_OFF: err_d = !div_ok;
				`UIQ_QCTRL_OFF, `UIQ_LINE_FMT_OFF, `UIQ_EXT_FEAT_OFF,
				`UIQ_IRQ_CLR_OFF, `UIQ_IRQ_EN_OFF,
				`UIQ_SW_RESET_OFF: err_d = 1'b0;
				default: err_d = 1'b1;
			endcase
		end
		// Access phase always one cycle: no wait states
		pready_d = psel && !penable;
		pslverr_d = pready_d && err_d;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			prdata <= rdata_d;
			pslverr <= pslverr_d;
			pready <= pready_d;
		end
	end

	// --------------------------------------------------------------
	// Elaboration checks
	// --------------------------------------------------------------
	// Zero length would end the flush after one busy cycle without waiting for the ack
	if (`UIQ_FLUSH_CYC == 2'h0) begin : g_bad_flush_len
		$error("uiq_ctrl: flush length must be nonzero");
	end
	// One aligned word per register on the byte-addressed bus
	if (((`UIQ_DIV_HIGH_OFF | `UIQ_SRC_ID_OFF | `UIQ_QCTRL_OFF |
		`UIQ_LINE_FMT_OFF | `UIQ_EXT_FEAT_OFF | `UIQ_IRQ_STAT_OFF |
		`UIQ_IRQ_CLR_OFF | `UIQ_IRQ_EN_OFF | `UIQ_SW_RESET_OFF |
		`UIQ_THRESH_OFF) & 12'h003) != 12'h000) begin : g_bad_align
		$error("uiq_ctrl: register offsets must be word aligned");
	end
	// A key without the select bit could never lock the divisor
	if ((`UIQ_BANK_KEY & 8'h80) == 8'h00) begin : g_bad_key
		$error("uiq_ctrl: bank key must carry the divisor select bit");
	end
endmodule // uiq_ctrl

// ==== uiq_txq_model.sv ====
`timescale 1ns/100ps
module uiq_txq_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tx_flush_q,
	input wire logic [3:0] ack_dly,
	output logic tx_flush_ack
);
// ----------------
// Flush handshake
// ----------------
logic [3:0] cnt_q, cnt_d;
always_comb begin
	cnt_d = tx_flush_q ? cnt_q + 4'h1 : 4'h0;
end
always_ff @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		cnt_q <= 4'h0;
	end else begin
		cnt_q <= cnt_d;
	end
end
// Long delay: block must end the flush by itself
assign tx_flush_ack = tx_flush_q && cnt_q >= ack_dly;
endmodule // uiq_txq_model

// ==== uiq_chk.sv ====
`timescale 1ns/100ps
`include "uiq_regs.svh"
module uiq_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] src_pend,
	input wire logic tx_flush_ack,
	input wire logic tx_flush_q,
	input wire logic fifo_en_q,
	input wire logic [7:0] divisor_high_q,
	input wire logic [6:0] rx_level_q,
	input wire logic [6:0] tx_level_q,
	input wire logic irq_q
);
// ----------------
// Checks
// ----------------
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
logic done, rd_id, en3;
assign done = psel && penable && pready;
assign rd_id = done && !pwrite && paddr == `UIQ_SRC_ID_OFF && !pslverr;
assign en3 = fifo_en_q;
a_pready_one: assert property (pready |=> !pready)
	else $error("pready held too long");
a_div_write: assert property ($changed(divisor_high_q) |->
	$past(done && pwrite && paddr == `UIQ_DIV_HIGH_OFF && !pslverr))
	else $error("divisor changed without write");
a_unmapped_err: assert property (pready && paddr == 12'h3FC |-> pslverr)
	else $error("unmapped access accepted");
a_id_idle: assert property (rd_id && $past(src_pend == 0) &&
	$past(src_pend == 0, 2) && $past(src_pend == 0, 3)
	|-> prdata[7:0] == {{2{fifo_en_q}}, 6'h01}) else $error("idle id wrong");
a_id_top: assert property (rd_id && $past(src_pend[0]) &&
	$past(src_pend[0], 2) && $past(src_pend[0], 3)
	|-> prdata[5:0] == `UIQ_ID_LINE_ERR) else $error("top id wrong");
a_rx_map: assert property (en3 && $past(en3) && $past(en3, 2) |->
	rx_level_q inside {7'd8, 7'd16, 7'd56, 7'd60}) else $error("rx level");
a_tx_map: assert property (en3 && $past(en3) && $past(en3, 2) |->
	tx_level_q inside {7'd8, 7'd16, 7'd32, 7'd56}) else $error("tx level");
a_off_one: assert property (!en3 && !$past(en3) && !$past(en3, 2) |->
	rx_level_q == 7'h01 && tx_level_q == 7'h01) else $error("level not one");
a_flush_ends: assert property ($rose(tx_flush_q) |-> ##[1:5] !tx_flush_q)
	else $error("flush did not end");
a_zero_noflush: assert property (done && pwrite &&
	paddr == `UIQ_QCTRL_OFF && !pwdata[2] && !tx_flush_q |=> !tx_flush_q)
	else $error("flush without request");
endmodule // uiq_chk
bind uiq_ctrl uiq_chk u_uiq_chk (.clk, .reset_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .src_pend, .tx_flush_ack,
	.tx_flush_q, .fifo_en_q, .divisor_high_q, .rx_level_q, .tx_level_q,
	.irq_q);

// ==== tb_top.sv ====
`timescale 1ns/100ps
`include "uiq_regs.svh"
module tb_top;
logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, e;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata;
logic [7:0] src_pend = 0, divisor_high_q, r;
logic pready, pslverr, tx_flush_ack, tx_flush_q, fifo_en_q, irq_q;
logic [6:0] rx_level_q, tx_level_q;
logic [3:0] ack_dly = 4'h1;
logic [7:0] pv [8] = '{8'hFF, 8'hFA, 8'hF4, 8'hF8, 8'hF0, 8'hE0, 8'hC0, 8'h80};
logic [5:0] ids [8] = '{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h30, 6'h10, 6'h20};
logic [6:0] rxt [4] = '{7'd8, 7'd16, 7'd56, 7'd60};
logic [6:0] txt [4] = '{7'd8, 7'd16, 7'd32, 7'd56};
int n_fail = 0, check_count = 0, cyc = 0, n;
always #2.5 clk = ~clk;
uiq_ctrl u_uiq_ctrl (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .src_pend, .tx_flush_ack,
	.tx_flush_q, .fifo_en_q, .divisor_high_q, .rx_level_q, .tx_level_q,
	.irq_q);
uiq_txq_model u_uiq_txq_model (.clk, .reset_n, .tx_flush_q, .ack_dly,
	.tx_flush_ack);
// ----------------
// Tasks
// ----------------
task chk(input logic [31:0] s, input logic [31:0] x);
	check_count++;
	if (s !== x) begin
		n_fail++;
		$display("unexpected at %0t: saw %h want %h", $time, s, x);
	end
endtask
task final_report;
	$display("checks %0d mismatches %0d", check_count, n_fail);
	if (n_fail == 0 && check_count > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
// Idle edge at the end keeps psel from being set twice in one step
task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
	psel <= 1;
	pwrite <= w;
	paddr <= a;
	pwdata <= {24'h0, d};
	@(posedge clk);
	penable <= 1;
	@(posedge clk);
	while (pready !== 1'b1) @(posedge clk);
	r = prdata[7:0];
	e = pslverr;
	psel <= 0;
	penable <= 0;
	@(posedge clk);
endtask
task rdc(input logic [11:0] a, input logic [7:0] x);
	apb(0, a, 0);
	chk(r, x);
	chk(e, 0);
endtask
always @(posedge clk) begin
	cyc++;
	if (cyc == 5000) begin
		n_fail++;
		final_report;
	end
end
// ----------------
// Sequence
// ----------------
initial begin
	repeat (4) @(posedge clk);
	reset_n <= 1;
	@(posedge clk);
	chk({rx_level_q, tx_level_q}, {7'h01, 7'h01});
	rdc(`UIQ_SRC_ID_OFF, `UIQ_SRC_ID_RST);
	apb(0, `UIQ_DIV_HIGH_OFF, 0);
	chk(e, 1);
	apb(1, `UIQ_LINE_FMT_OFF, 8'h80);
	apb(1, `UIQ_DIV_HIGH_OFF, 8'hA5);
	rdc(`UIQ_DIV_HIGH_OFF, 8'hA5);
	apb(1, `UIQ_LINE_FMT_OFF, `UIQ_BANK_KEY);
	apb(0, `UIQ_DIV_HIGH_OFF, 0);
	chk(e, 1);
	apb(1, `UIQ_SW_RESET_OFF, 8'h01);
	chk(divisor_high_q, 8'hA5);
	reset_n <= 0;
	@(posedge clk);
	reset_n <= 1;
	@(posedge clk);
	chk(divisor_high_q, 0);
	apb(0, 12'h3FC, 0);
	chk(e, 1);
	apb(1, `UIQ_QCTRL_OFF, 8'hC0);
	@(posedge clk);
	chk(rx_level_q, 1);
	chk(fifo_en_q, 0);
	rdc(`UIQ_QCTRL_OFF, 8'h00);
	for (int i = 0; i < 4; i++) begin
		apb(1, `UIQ_QCTRL_OFF, {i[1:0], 6'h11});
		@(posedge clk);
		chk(rx_level_q, rxt[i]);
		chk(tx_level_q, txt[0]);
	end
	apb(1, `UIQ_EXT_FEAT_OFF, 8'h10);
	for (int i = 0; i < 4; i++) begin
		apb(1, `UIQ_QCTRL_OFF, {2'b00, i[1:0], 4'h1});
		@(posedge clk);
		chk(tx_level_q, txt[i]);
	end
	for (int i = 0; i < 8; i++) begin
		src_pend <= pv[i];
		repeat (3) @(posedge clk);
		rdc(`UIQ_SRC_ID_OFF, {2'b11, ids[i]});
	end
	src_pend <= 0;
	repeat (3) @(posedge clk);
	rdc(`UIQ_SRC_ID_OFF, 8'hC1);
	apb(1, `UIQ_IRQ_CLR_OFF, 8'hFF);
	apb(1, `UIQ_IRQ_EN_OFF, 8'h01);
	src_pend <= 8'h01;
	@(posedge clk);
	src_pend <= 0;
	repeat (3) @(posedge clk);
	chk(irq_q, 1);
	rdc(`UIQ_IRQ_STAT_OFF, 8'h01);
	apb(1, `UIQ_IRQ_EN_OFF, 8'h00);
	@(posedge clk);
	chk(irq_q, 0);
	apb(1, `UIQ_IRQ_EN_OFF, 8'h01);
	@(posedge clk);
	chk(irq_q, 1);
	apb(1, `UIQ_IRQ_CLR_OFF, 8'h01);
	@(posedge clk);
	chk(irq_q, 0);
	rdc(`UIQ_IRQ_STAT_OFF, 8'h00);
	for (int i = 0; i < 2; i++) begin
		ack_dly <= i ? 4'hF : 4'h1;
		apb(1, `UIQ_QCTRL_OFF, 8'h01);
		chk(tx_flush_q, 0);
		apb(1, `UIQ_QCTRL_OFF, 8'h05);
		chk(tx_flush_q, 1);
		n = 0;
		while (tx_flush_q === 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		chk(n < 5, 1);
		rdc(`UIQ_QCTRL_OFF, 8'h01);
	end
	final_report;
end
endmodule // tb_top
